// ==== core/vid_seq_pkg.sv ====
// Shared constants, state codes and helpers for the reference sequencer.
// Assumes a single 125 MHz core clock and an APB register slave.
package vid_seq_pkg;

    // Clock and derived rates
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned STEP_HZ_STEPPED = 1_000_000;
    localparam int unsigned STEP_HZ_DIRECT  = 250_000;
    localparam int unsigned MAIN_OSC_HZ     = 200_000;
    localparam int unsigned SS_OSC_HZ       = 1_000_000;
    localparam int unsigned STEP_CYC_STEPPED = CLK_HZ / STEP_HZ_STEPPED;
    localparam int unsigned STEP_CYC_DIRECT  = CLK_HZ / STEP_HZ_DIRECT;
    localparam int unsigned MAIN_OSC_CYC     = CLK_HZ / MAIN_OSC_HZ;

    // Soft-start timing in microseconds; least delay rounds up
    localparam int unsigned T_DELAY_US  = 1000;
    localparam int unsigned T_HOLD_US   = 75;
    localparam int unsigned T_DELAY_CYC = (T_DELAY_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned T_HOLD_CYC  = T_HOLD_US * (CLK_HZ / 1_000_000);

    // Protection mask tail in step-clock cycles
    localparam logic [5:0]  MASK_CLOCKS = 6'h20;

    // DAC step sizes in microvolts and levels in millivolts
    localparam int unsigned LSB_UV_STEPPED = 6250;
    localparam int unsigned LSB_UV_DIRECT  = 25000;
    localparam int unsigned UV_ENABLE_MV   = 600;
    localparam int unsigned BOOT_MV        = 1081;

    // Overvoltage threshold selection codes (fixed 1.24 V, fixed 1.800 V, code-based, programmed)
    localparam logic [1:0]  OVP_FIX_1240 = 2'h0;
    localparam logic [1:0]  OVP_FIX_1800 = 2'h1;
    localparam logic [1:0]  OVP_CODE     = 2'h2;
    localparam logic [1:0]  OVP_PROG     = 2'h3;

    // Register map and fields
    localparam logic [11:0] REG_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] REG_STATUS_ADDR = 12'h004;
    localparam int unsigned CTRL_DIRECT_BIT = 0;
    localparam int unsigned CTRL_OVPRG_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    localparam int unsigned ST_REF_LSB      = 0;
    localparam int unsigned ST_TGT_LSB      = 8;
    localparam int unsigned ST_STATE_LSB    = 16;
    localparam int unsigned ST_OVF_BIT      = 24;
    localparam int unsigned ST_UVF_BIT      = 25;
    localparam int unsigned ST_BUSY_BIT     = 26;
    localparam int unsigned ST_MASK_BIT     = 27;
    localparam int unsigned ST_DONE_BIT     = 28;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_OFF   = 6'h01,
        ST_DELAY = 6'h02,
        ST_BOOT  = 6'h04,
        ST_HOLD  = 6'h08,
        ST_FINAL = 6'h10,
        ST_RUN   = 6'h20
    } seq_state_t;

    // Smallest code that reaches a level, rounding up
    function automatic logic [15:0] mv_to_code(input int unsigned mv, input int unsigned lsb_uv);
        mv_to_code = 16'((mv * 1000 + lsb_uv - 1) / lsb_uv);
    endfunction : mv_to_code

    // Free-running divider step: wraps at period-1
    function automatic logic [19:0] div_next(input logic [19:0] cnt, input int unsigned period);
        div_next = (cnt >= 20'(period - 1)) ? 20'h00000 : cnt + 20'h00001;
    endfunction : div_next

endpackage : vid_seq_pkg

// ==== core/vid_reference_sequencer.sv ====
// Reference sequencer: code-change stepping, soft start, protection gating.
// Assumes pins arrive asynchronously, analog comparators outside, APB master.
//
// Behaviour
// RULE1: Mask monitors during transition plus 32 clocks
// RULE2: One step equals one DAC code
// RULE3: Sample code on rise, confirm on fall
// RULE4: Next rise, step once per cycle to target
// RULE5: Ignore code during transition, resume next rise
// RULE6: Step clock 1 MHz stepped, 250 kHz direct
// RULE7: Direct profile flags transition including mask tail
// RULE8: Source should change code one step paced
// RULE9: Supply bad means shutdown, gates off
// RULE10: Enable low clears faults, done, gates
// RULE11: Start only with supplies good and enabled
// RULE12: Release done once soft start completes
// RULE13: Undervoltage off below 0.6 V, overvoltage always; in run the code enables undervoltage whenever unmasked, at any level
// RULE14: Stepped: wait 1 ms, ramp to boot
// RULE15: Stepped: hold boot 75 us, then ramp
// RULE16: Stepped ramp uses own soft-start oscillator
// RULE17: Stepped: 1.24 V overvoltage until boot reached; with CTRL_OVPRG_BIT set the code selects the programmed threshold instead
// RULE18: Code below boot steps down from boot
// RULE19: Direct: ramp from zero on main oscillator
// RULE20: Direct soft start: 1.800 V or programmed threshold
// RULE21: Shutdown or disable resets reference and sequencer
`timescale 1ns/1ps

module vid_reference_sequencer
    import vid_seq_pkg::*;
#(
    parameter int unsigned CODE_W     = 8,
    parameter int unsigned DELAY_CYC  = T_DELAY_CYC,
    parameter int unsigned HOLD_CYC   = T_HOLD_CYC,
    parameter int unsigned SS_OSC_CYC = CLK_HZ / SS_OSC_HZ
) (
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RST_B,
    input  wire logic [CODE_W-1:0] I_VOLTAGE_ID_CODE,
    input  wire logic              I_CTRL_SUPPLY_OK,
    input  wire logic              I_DRIVER_SUPPLY_OK,
    input  wire logic              I_OUTPUT_ENABLE_PIN,
    input  wire logic              I_OV_TRIP,
    input  wire logic              I_UV_TRIP,
    input  wire logic              I_PG_LOW,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [11:0]       I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic      [31:0]       O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    output logic      [CODE_W-1:0] O_REF_CODE,
    output logic                   O_LSB_25MV,
    output logic                   O_GATE_EN,
    output logic                   O_LS_FORCE,
    output logic                   O_SOFTSTART_DONE_OUTPUT,
    output logic                   O_TRANSITION_ACTIVE_OUTPUT,
    output logic                   O_POWER_GOOD_FLAG,
    output logic                   O_MONITOR_MASK,
    output logic                   O_UVP_EN,
    output logic      [1:0]        O_OVP_SEL
);

    typedef struct packed {
        logic [CODE_W-1:0] vid_s1;
        logic [CODE_W-1:0] vid_s2;
        logic [CODE_W-1:0] vid_s3;
        logic [CODE_W-1:0] vid_f;
        logic [5:0]        pin_s1;
        logic [5:0]        pin_s2;
        logic [5:0]        pin_s3;
        logic [5:0]        pin_f;
        logic [19:0]       step_cnt;
        logic [19:0]       ss_cnt;
        logic [19:0]       main_cnt;
        logic [19:0]       wait_cnt;
        seq_state_t        state;
        logic              direct;
        logic [1:0]        ctrl;
        logic [CODE_W-1:0] ref_code;
        logic [CODE_W-1:0] target;
        logic [CODE_W-1:0] cand;
        logic              pending;
        logic              busy;
        logic [5:0]        mask_cnt;
        logic              ov_fault;
        logic              uv_fault;
        logic              done;
        logic              power_good_flag;
        logic              gate_en;
        logic              mask_out;
        logic              trans_active;
        logic              uvp_en;
        logic [1:0]        ovp_sel;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } seq_regs_t;

    localparam seq_regs_t REGS_RESET = '{state: ST_OFF, ctrl: CTRL_RESET, default: '0};

    seq_regs_t st;
    seq_regs_t next_st;

    // Pin bits gathered for one synchroniser
    logic [5:0] pin_raw;
    assign pin_raw = {I_PG_LOW, I_UV_TRIP, I_OV_TRIP, I_OUTPUT_ENABLE_PIN,
                      I_DRIVER_SUPPLY_OK, I_CTRL_SUPPLY_OK};

    // Helpers decoded from the current state
    logic              sup_ok;
    logic              oe_ok;
    logic              step_rise;
    logic              step_fall;
    logic              ramp_tick;
    logic              ss_tick;
    logic              main_tick;
    logic [CODE_W-1:0] boot_code;
    logic [CODE_W-1:0] uv_code;
    int unsigned       step_period;
    logic              access;

    // Whole sequencer next state
    always_comb begin
        next_st = st;

        // Three-stage synchronisers; a value counts once stages two and three agree
        next_st.vid_s1 = I_VOLTAGE_ID_CODE;
        next_st.vid_s2 = st.vid_s1;
        next_st.vid_s3 = st.vid_s2;
        if (st.vid_s2 == st.vid_s3) begin
            next_st.vid_f = st.vid_s3;
        end
        next_st.pin_s1 = pin_raw;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_s3 = st.pin_s2;
        for (int i = 0; i < 6; i++) begin
            if (st.pin_s2[i] == st.pin_s3[i]) begin
                next_st.pin_f[i] = st.pin_s3[i];
            end
        end
        sup_ok = st.pin_f[0] & st.pin_f[1];
        oe_ok  = st.pin_f[2];

        // Step clock rate follows the profile
        step_period      = st.direct ? STEP_CYC_DIRECT : STEP_CYC_STEPPED; // RULE6
        next_st.step_cnt = div_next(st.step_cnt, step_period);
        step_rise        = (st.step_cnt == 20'h00000);
        step_fall        = (st.step_cnt == 20'(step_period / 2));
        // Soft-start oscillator kept apart from the main oscillator
        next_st.ss_cnt   = div_next(st.ss_cnt, SS_OSC_CYC); // RULE16
        next_st.main_cnt = div_next(st.main_cnt, MAIN_OSC_CYC);
        ss_tick          = (st.ss_cnt == 20'h00000);
        main_tick        = (st.main_cnt == 20'h00000);
        ramp_tick        = st.direct ? main_tick : ss_tick; // RULE19

        // Levels converted to codes: boot in stepped codes, undervoltage in the active step size
        boot_code = CODE_W'(mv_to_code(BOOT_MV, LSB_UV_STEPPED));
        uv_code   = CODE_W'(mv_to_code(UV_ENABLE_MV,
                                       st.direct ? LSB_UV_DIRECT : LSB_UV_STEPPED));

        unique case (st.state)
            ST_OFF: begin
                next_st.direct   = st.ctrl[CTRL_DIRECT_BIT];
                next_st.wait_cnt = 20'h00000;
                if (sup_ok && oe_ok) begin // RULE11
                    next_st.state = st.ctrl[CTRL_DIRECT_BIT] ? ST_FINAL : ST_DELAY;
                end
            end
            ST_DELAY: begin
                next_st.wait_cnt = st.wait_cnt + 20'h00001;
                if (st.wait_cnt >= 20'(DELAY_CYC - 1)) begin // RULE14
                    next_st.state = ST_BOOT;
                end
            end
            ST_BOOT: begin
                next_st.wait_cnt = 20'h00000;
                if (st.ref_code >= boot_code) begin
                    next_st.state = ST_HOLD;
                end else if (ss_tick) begin
                    next_st.ref_code = st.ref_code + 1'b1; // RULE14
                end
            end
            ST_HOLD: begin
                next_st.wait_cnt = st.wait_cnt + 20'h00001;
                if (st.wait_cnt >= 20'(HOLD_CYC - 1)) begin // RULE15
                    next_st.target = st.vid_f;
                    next_st.state  = ST_FINAL;
                end
            end
            ST_FINAL: begin
                // Direct profile tracks the lines live; stepped keeps the held code
                if (st.direct) begin
                    next_st.target = st.vid_f;
                end
                if (ramp_tick) begin
                    if (st.ref_code < st.target) begin
                        next_st.ref_code = st.ref_code + 1'b1; // RULE2
                    end else if (st.ref_code > st.target) begin
                        next_st.ref_code = st.ref_code - 1'b1; // RULE18
                    end else begin
                        next_st.state = ST_RUN;
                        next_st.done  = 1'b1; // RULE12
                    end
                end
            end
            ST_RUN: begin
                if (step_rise) begin
                    if (st.busy) begin
                        // One code per step-clock cycle toward the target
                        if (st.ref_code < st.target) begin
                            next_st.ref_code = st.ref_code + 1'b1; // RULE4
                        end else begin
                            next_st.ref_code = st.ref_code - 1'b1; // RULE4
                        end
                        if (next_st.ref_code == st.target) begin
                            next_st.busy     = 1'b0; // RULE5
                            next_st.mask_cnt = MASK_CLOCKS; // RULE1
                        end
                    end else begin
                        if (st.mask_cnt != 6'h00) begin
                            next_st.mask_cnt = st.mask_cnt - 6'h01; // RULE1
                        end
                        // Large jumps are still taken at full step rate
                        if (!st.pending && st.vid_f != st.ref_code) begin
                            next_st.pending = 1'b1; // RULE3
                            next_st.cand    = st.vid_f;
                        end
                    end
                end
                if (step_fall && st.pending) begin
                    next_st.pending = 1'b0;
                    if (st.vid_f == st.cand) begin
                        next_st.busy   = 1'b1; // RULE3
                        next_st.target = st.cand;
                    end
                end
            end
        endcase

        // Latched faults; masked monitors cannot trip
        if (st.state != ST_OFF && !st.mask_out) begin
            if (st.pin_f[3]) begin
                next_st.ov_fault = 1'b1; // RULE13
            end
            if (st.pin_f[4] && st.uvp_en) begin
                next_st.uv_fault = 1'b1;
            end
        end
        // Power good only updates outside a transition
        if (!st.mask_out) begin
            next_st.power_good_flag = st.done && !st.pin_f[5]; // RULE1
        end

        // Supply loss or disable overrides everything and restarts from zero
        if (!sup_ok || !oe_ok) begin
            next_st.state    = ST_OFF; // RULE21
            next_st.ref_code = '0; // RULE21
            next_st.target   = '0;
            next_st.pending  = 1'b0;
            next_st.busy     = 1'b0;
            next_st.mask_cnt = 6'h00;
            next_st.done     = 1'b0; // RULE10
            next_st.power_good_flag    = 1'b0;
            next_st.ov_fault = 1'b0; // RULE10
            next_st.uv_fault = 1'b0; // RULE10
        end

        // Outputs registered from the next state so they line up with it
        next_st.gate_en  = (next_st.state != ST_OFF) && !next_st.ov_fault &&
                           !next_st.uv_fault; // RULE9
        next_st.mask_out = next_st.busy || (next_st.mask_cnt != 6'h00); // RULE1
        next_st.trans_active = next_st.direct && next_st.mask_out; // RULE7
        if (next_st.state == ST_RUN) begin
            next_st.uvp_en = !next_st.mask_out;
        end else begin
            next_st.uvp_en = (next_st.state != ST_OFF) && (next_st.state != ST_DELAY) &&
                             (next_st.ref_code >= uv_code); // RULE13
        end
        if (st.ctrl[CTRL_OVPRG_BIT]) begin
            next_st.ovp_sel = OVP_PROG;
        end else if (!next_st.direct &&
                     (next_st.state == ST_DELAY || next_st.state == ST_BOOT)) begin
            next_st.ovp_sel = OVP_FIX_1240; // RULE17
        end else if (next_st.direct && next_st.state != ST_RUN) begin
            next_st.ovp_sel = OVP_FIX_1800; // RULE20
        end else begin
            next_st.ovp_sel = OVP_CODE; // RULE17
        end

        // APB slave: one wait state, answer on the second access cycle
        access          = I_PSEL && I_PENABLE && !st.pready;
        next_st.pready  = access;
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h00000000;
        if (access) begin
            if (I_PADDR == REG_CTRL_ADDR) begin
                if (I_PWRITE) begin
                    next_st.ctrl = I_PWDATA[1:0];
                end
                next_st.prdata[1:0] = st.ctrl;
            end else if (I_PADDR == REG_STATUS_ADDR) begin
                next_st.prdata[ST_REF_LSB +: CODE_W]   = st.ref_code;
                next_st.prdata[ST_TGT_LSB +: CODE_W]   = st.target;
                next_st.prdata[ST_STATE_LSB +: 6]      = st.state;
                next_st.prdata[ST_OVF_BIT]             = st.ov_fault;
                next_st.prdata[ST_UVF_BIT]             = st.uv_fault;
                next_st.prdata[ST_BUSY_BIT]            = st.busy;
                next_st.prdata[ST_MASK_BIT]            = st.mask_out;
                next_st.prdata[ST_DONE_BIT]            = st.done;
            end else begin
                next_st.pslverr = 1'b1; // Unmapped address
            end
        end
    end

    // Single register bank, synchronous active-low reset
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            st <= REGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Ports straight from the register bank
    assign O_PRDATA                   = st.prdata;
    assign O_PREADY                   = st.pready;
    assign O_PSLVERR                  = st.pslverr;
    assign O_REF_CODE                 = st.ref_code;
    assign O_LSB_25MV                 = st.direct; // RULE2
    assign O_GATE_EN                  = st.gate_en;
    assign O_LS_FORCE                 = st.ov_fault;
    assign O_SOFTSTART_DONE_OUTPUT    = st.done;
    assign O_TRANSITION_ACTIVE_OUTPUT = st.trans_active;
    assign O_POWER_GOOD_FLAG          = st.power_good_flag;
    assign O_MONITOR_MASK             = st.mask_out;
    assign O_UVP_EN                   = st.uvp_en;
    assign O_OVP_SEL                  = st.ovp_sel;

    // Checks on the sequencer
    a_shutdown_gates_off: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE9
        !(st.pin_f[0] && st.pin_f[1]) |=> !st.gate_en && st.state == ST_OFF)
        else $error("gates on during supply shutdown");

    a_disable_clears_all: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE10
        !st.pin_f[2] |=> !st.done && !st.ov_fault && !st.uv_fault && !st.gate_en)
        else $error("disable did not clear faults and done");

    a_start_needs_enable: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE11
        (st.state == ST_OFF ##1 st.state != ST_OFF) |-> $past(st.pin_f[2] && st.pin_f[0]))
        else $error("soft start left idle without enable");

    a_off_ref_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE21
        $past(st.state) == ST_OFF && st.state == ST_OFF |-> st.ref_code == '0)
        else $error("reference not zero in idle");

    a_mask_tail_load: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE1
        (st.busy ##1 (!st.busy && st.state == ST_RUN)) |-> st.mask_cnt == MASK_CLOCKS &&
        st.mask_out)
        else $error("mask tail not loaded at transition end");

    a_run_single_step: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE4
        (st.state == ST_RUN && $past(st.state) == ST_RUN && $changed(st.ref_code)) |->
        ($past(st.busy) && (st.ref_code == CODE_W'($past(st.ref_code) + 1'b1) ||
                            st.ref_code == CODE_W'($past(st.ref_code) - 1'b1))))
        else $error("reference moved by more than one code");

    a_uv_below_level: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE13
        (st.state != ST_RUN && st.ref_code < uv_code) |-> !st.uvp_en)
        else $error("undervoltage enabled below level");

    a_ovp_fixed_boot: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE17
        (!st.direct && !st.ctrl[CTRL_OVPRG_BIT] && st.state == ST_BOOT ##1
         st.state == ST_BOOT) |-> st.ovp_sel == OVP_FIX_1240)
        else $error("stepped boot ramp without fixed overvoltage level");

    a_direct_flag: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE7
        (st.direct && st.mask_cnt != 6'h00) |-> st.trans_active)
        else $error("direct transition flag dropped during mask tail");

    a_done_on_run: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B) // RULE12
        $rose(st.done) |-> st.state == ST_RUN && $past(st.state) == ST_FINAL)
        else $error("done released outside soft-start completion");

endmodule : vid_reference_sequencer

// ==== testbench/vid_source.sv ====
// Load processor model driving the identification code lines.
// Assumes the bench calls move_to from its own clock domain.
`timescale 1ns/1ps

module vid_source (
    input  wire logic       i_clk,
    output logic      [7:0] o_code
);
    // Start below the boot level so a stepped start must step down
    initial o_code = 8'hAA;

    // One new code per call, then held for a pace of cycles
    task automatic move_to(input logic [7:0] c, input int pace);
        @(posedge i_clk);
        o_code <= c;
        repeat (pace) @(posedge i_clk);
    endtask : move_to
endmodule : vid_source

// ==== testbench/test_vid_reference_sequencer.sv ====
// Self-checking bench for the reference sequencer.
// Assumes short delay, hold and soft-start divider parameters.
`timescale 1ns/1ps

module test_vid_reference_sequencer;
    import vid_seq_pkg::*;
    logic        clk, rst_b, sc, sd, en, ov, psel, pen, pwr, err, uv, pgl;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, lsb, gate, done, act, mask, undervoltage_protect, lsf, pg;
    logic [7:0]  code, ref_c;
    logic [1:0]  overvoltage_protect;
    int          error_cnt = 0;
    int          checks = 0;

    vid_source u_vid_source (.i_clk(clk), .o_code(code));

    // Short counts keep the run small
    vid_reference_sequencer #(.DELAY_CYC(50), .HOLD_CYC(20), .SS_OSC_CYC(4))
    u_vid_reference_sequencer (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_VOLTAGE_ID_CODE(code),
        .I_CTRL_SUPPLY_OK(sc), .I_DRIVER_SUPPLY_OK(sd), .I_OUTPUT_ENABLE_PIN(en),
        .I_OV_TRIP(ov), .I_UV_TRIP(uv), .I_PG_LOW(pgl), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_REF_CODE(ref_c), .O_LSB_25MV(lsb), .O_GATE_EN(gate), .O_LS_FORCE(lsf),
        .O_SOFTSTART_DONE_OUTPUT(done), .O_TRANSITION_ACTIVE_OUTPUT(act),
        .O_POWER_GOOD_FLAG(pg), .O_MONITOR_MASK(mask), .O_UVP_EN(undervoltage_protect),
        .O_OVP_SEL(overvoltage_protect));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    // Setup then access, held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    // Bounded waits; running out counts as a mismatch
    task automatic wait_ref(input logic [7:0] r, input int lim);
        int n = 0;
        while (ref_c !== r && n < lim) begin
            @(posedge clk);
            n++;
        end
        check(32'(ref_c), 32'(r));
    endtask : wait_ref

    task automatic wait_done(input int lim);
        int n = 0;
        while (done !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        check(32'(done), 32'h1);
    endtask : wait_done

    task automatic t_off;
        repeat (10) @(posedge clk);
        check(32'({gate, done}), 32'h0);
        apb(1'b0, REG_STATUS_ADDR, 32'h0);
        check(32'(rd[21:16]), 32'(ST_OFF));
        apb(1'b0, 12'h008, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
    endtask : t_off

    task automatic t_boot;
        sc <= 1'b1;
        sd <= 1'b1;
        wait_ref(8'h32, 2000);
        check(32'({overvoltage_protect, undervoltage_protect, lsb}), {28'h0, OVP_FIX_1240, 2'h0});
        wait_done(3000);
        check(32'({ref_c, overvoltage_protect, gate}), {21'h0, 8'hAA, OVP_CODE, 1'b1});
    endtask : t_boot

    // One code up; monitors stay masked for the tail
    task automatic t_step;
        u_vid_source.move_to(8'hAB, 10);
        wait_ref(8'hAB, 400);
        check(32'({pg, mask, act}), 32'h6);
        repeat (3950) @(posedge clk);
        check(32'({mask, undervoltage_protect}), 32'h2);
        repeat (150) @(posedge clk);
        check(32'({mask, undervoltage_protect}), 32'h1);
    endtask : t_step

    // Undervoltage stops switching without forcing the low sides
    task automatic t_fault;
        uv <= 1'b1;
        pgl <= 1'b1;
        repeat (10) @(posedge clk);
        check(32'({pg, gate, lsf}), 32'h0);
        ov <= 1'b1;
        repeat (10) @(posedge clk);
        check(32'(lsf), 32'h1);
        en <= 1'b0;
        ov <= 1'b0;
        uv <= 1'b0;
        pgl <= 1'b0;
        repeat (10) @(posedge clk);
        check(32'({lsf, done, gate, ref_c}), 32'h0);
    endtask : t_fault

    task automatic t_direct;
        apb(1'b1, REG_CTRL_ADDR, 32'h1);
        u_vid_source.move_to(8'h1E, 1);
        en <= 1'b1;
        wait_ref(8'h0A, 20000);
        check(32'({overvoltage_protect, lsb}), {29'h0, OVP_FIX_1800, 1'b1});
        wait_done(20000);
        u_vid_source.move_to(8'h1F, 1);
        wait_ref(8'h1F, 1500);
        repeat (15900) @(posedge clk);
        check(32'(act), 32'h1);
        repeat (700) @(posedge clk);
        check(32'(act), 32'h0);
        sd <= 1'b0;
        repeat (10) @(posedge clk);
        check(32'(gate), 32'h0);
        apb(1'b1, REG_CTRL_ADDR, 32'h3);
        apb(1'b0, REG_CTRL_ADDR, 32'h0);
        check(rd, 32'h3);
        check(32'(overvoltage_protect), 32'(OVP_PROG));
    endtask : t_direct

    // 125 MHz core clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Limit well above the expected 40k cycles
    initial begin
        #700_000;
        error_cnt++;
        results();
    end

    initial begin
        {rst_b, sc, sd, ov, uv, pgl, psel, pen, pwr, paddr, pwdata} = '0;
        en = 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_off();
        t_boot();
        t_step();
        t_fault();
        t_direct();
        results();
    end
endmodule : test_vid_reference_sequencer
